//--- logic/viu_device.sv
// viu_device: vectored interrupt unit with status, masks, pointer and acknowledge.
// assumes: link strobes are synchronous to clock_i; events are one-cycle pulses.
// Contract
// RULE1 - pointer read first; status read clears bits
// RULE2 - request drops when pointer fully clear
// RULE3 - strobe style two pulses, direction style one
// RULE4 - slave mode: acknowledge only on matching address
// RULE5 - single device ties address pins to match
// RULE6 - daisy mode: acknowledge needs chain enable in
// RULE7 - chain out follows in, blocked by request
// RULE8 - daisy: no new request during acknowledge
// RULE9 - vector driven on low eight data lines
// RULE10 - eight groups, group one highest
// RULE11 - groups one to six self-clear after acknowledge
// RULE12 - groups seven, eight need pointer and status reads
// RULE13 - lone port event reported as group seven
// RULE14 - daisy: chain enable in gates request
// RULE15 - vector picks one unmasked source by priority
// RULE16 - visibility off: masked bits fully hidden
// RULE17 - visibility on: masked bits shown, no request
// RULE18 - visibility on: read clears masked bits too
// RULE19 - pointer flags each register with unmasked bits
// RULE20 - each status bit has its own mask
// RULE21 - request drive open drain or push-pull
// RULE22 - vector encodes group and channel
// RULE23 - vector and group held through acknowledge
`timescale 1ns/1ps
module viu_device (
   input  wire logic       clock_i,
   input  wire logic       arst_n_i,
   viu_link_if.dev         link,
   input  wire logic [7:0] ev_first_a_i,
   input  wire logic [7:0] ev_second_a_i,
   input  wire logic [7:0] ev_first_b_i,
   input  wire logic [7:0] ev_second_b_i,
   input  wire logic [7:0] ev_port_i,
   output logic            irq_active_o,
   output logic [7:0]      last_vector_o
);
   typedef struct packed {
      logic [viu_pkg::N_STAT-1:0][7:0] st;
      logic [viu_pkg::N_STAT-1:0][7:0] msk;
      logic [7:0]                      irq_port_config;
      viu_pkg::viu_dack_t              ack;
      logic                            acc;
      logic [3:0]                      grp;
      logic [7:0]                      vec;
      logic [15:0]                     dout;
      logic                            dout_oe;
      logic                            irq;
   } viu_dev_t;

   viu_dev_t s;
   viu_dev_t next_s;
   logic [viu_pkg::N_STAT-1:0][7:0] ev;
   logic [viu_pkg::N_STAT-1:0][7:0] eff;
   logic [viu_pkg::N_STAT-1:0]      global_pending_pointer;
   logic [3:0] win_grp;
   logic       win_ch;
   logic       daisy;
   logic       chain_in;
   logic       accept;
   logic       pending;
   logic [3:0] ri;

   assign ev = {ev_port_i, ev_second_b_i, ev_first_b_i, ev_second_a_i, ev_first_a_i};
   assign daisy = s.irq_port_config[viu_pkg::IPC_DAISY];
   assign chain_in = link.chain_en_in_or_addr_hi;
   assign ri = link.addr;

   always_comb begin
      for (int i = 0; i < viu_pkg::N_STAT; i++) begin
         eff[i] = s.st[i] & ~s.msk[i]; // RULE20 RULE15
         global_pending_pointer[i] = |eff[i]; // RULE19
      end
   end
   assign pending = |global_pending_pointer;

   // fixed priority; urgent bits first, then remaining bits per channel
   always_comb begin
      win_grp = viu_pkg::GRP_NONE;
      win_ch = 1'b0;
      if (eff[0][viu_pkg::URG_RX0]) begin // RULE10
         win_grp = 4'h1;
      end else if (eff[2][viu_pkg::URG_RX0]) begin
         win_grp = 4'h2;
         win_ch = 1'b1;
      end else if (eff[0][viu_pkg::URG_RX1]) begin
         win_grp = 4'h3;
      end else if (eff[2][viu_pkg::URG_RX1]) begin
         win_grp = 4'h4;
         win_ch = 1'b1;
      end else if (eff[1][viu_pkg::URG_TX0]) begin
         win_grp = 4'h5;
      end else if (eff[3][viu_pkg::URG_TX0]) begin
         win_grp = viu_pkg::GRP_LAST_URGENT;
         win_ch = 1'b1;
      end else if (|(eff[0] & viu_pkg::ST_OTHER_FIRST) || |(eff[1] & viu_pkg::ST_OTHER_SECOND)
                   || global_pending_pointer[4]) begin
         win_grp = viu_pkg::GRP_7; // RULE13 RULE12
      end else if (|(eff[2] & viu_pkg::ST_OTHER_FIRST) || |(eff[3] & viu_pkg::ST_OTHER_SECOND)) begin
         win_grp = viu_pkg::GRP_8;
         win_ch = 1'b1;
      end
   end

   always_comb begin
      if (daisy) begin
         accept = chain_in; // RULE6
      end else begin
         accept = {chain_in, link.chain_en_out_or_addr_lo} ==
                  {s.irq_port_config[viu_pkg::IPC_ADDR_HI], s.irq_port_config[viu_pkg::IPC_ADDR_LO]}; // RULE4 RULE5
      end
   end

   always_comb begin
      logic [viu_pkg::N_STAT-1:0][7:0] clr;
      logic take;
      clr = '0;
      take = 1'b0;
      next_s = s;
      next_s.dout_oe = 1'b0;
      // register access
      if (link.wr) begin
         if (ri >= viu_pkg::IX_MASK_BASE && ri <= viu_pkg::IX_MASK_LAST) begin
            next_s.msk[3'(ri - viu_pkg::IX_MASK_BASE)] = link.wdata;
         end else if (ri == viu_pkg::IX_IRQ_PORT_CONFIG) begin
            next_s.irq_port_config = link.wdata & viu_pkg::IPC_WMASK; // RULE21
         end
      end
      if (link.rd) begin
         next_s.dout_oe = 1'b1;
         next_s.dout = '0;
         if (ri <= viu_pkg::IX_PORT_EVENT_STATUS) begin
            if (s.irq_port_config[viu_pkg::IPC_VISIBLE]) begin
               next_s.dout[7:0] = s.st[3'(ri)]; // RULE17
               clr[3'(ri)] = s.st[3'(ri)]; // RULE18
            end else begin
               next_s.dout[7:0] = eff[3'(ri)]; // RULE16
               clr[3'(ri)] = eff[3'(ri)]; // RULE1
            end
         end else if (ri >= viu_pkg::IX_MASK_BASE && ri <= viu_pkg::IX_MASK_LAST) begin
            next_s.dout[7:0] = s.msk[3'(ri - viu_pkg::IX_MASK_BASE)];
         end else if (ri == viu_pkg::IX_GLOBAL_POINTER) begin
            next_s.dout[7:0] = {3'b000, global_pending_pointer}; // RULE1
         end else if (ri == viu_pkg::IX_IRQ_PORT_CONFIG) begin
            next_s.dout[7:0] = s.irq_port_config;
         end
      end
      // acknowledge sequence
      case (s.ack)
         viu_pkg::DA_IDLE: begin
            if (link.irq_ack_in) begin
               take = 1'b1;
               next_s.ack = s.irq_port_config[viu_pkg::IPC_ONE_PULSE] ? viu_pkg::DA_P2
                                                          : viu_pkg::DA_P1; // RULE3
            end
         end
         viu_pkg::DA_P1: begin
            if (!link.irq_ack_in) begin
               next_s.ack = viu_pkg::DA_GAP;
            end
         end
         viu_pkg::DA_GAP: begin
            if (link.irq_ack_in) begin
               next_s.ack = viu_pkg::DA_P2;
               next_s.dout_oe = s.acc;
            end
         end
         viu_pkg::DA_P2: begin
            next_s.dout_oe = s.acc | link.rd;
            if (!link.irq_ack_in) begin
               next_s.ack = viu_pkg::DA_IDLE;
               next_s.dout_oe = link.rd;
               if (s.acc) begin // RULE11
                  case (s.grp)
                     4'h1: clr[0][viu_pkg::URG_RX0] = 1'b1;
                     4'h2: clr[2][viu_pkg::URG_RX0] = 1'b1;
                     4'h3: clr[0][viu_pkg::URG_RX1] = 1'b1;
                     4'h4: clr[2][viu_pkg::URG_RX1] = 1'b1;
                     4'h5: clr[1][viu_pkg::URG_TX0] = 1'b1;
                     4'h6: clr[3][viu_pkg::URG_TX0] = 1'b1;
                     default: clr = clr;
                  endcase
               end
            end
         end
         default: next_s.ack = viu_pkg::DA_IDLE;
      endcase
      if (take) begin
         // frozen until the sequence ends
         next_s.acc = accept;
         next_s.grp = win_grp; // RULE23
         next_s.vec = 8'({win_grp, 4'h0} | (8'(win_ch) << viu_pkg::VEC_CH_BIT)); // RULE22
         next_s.dout = {8'h00, next_s.vec}; // RULE9
         next_s.dout_oe = accept & s.irq_port_config[viu_pkg::IPC_ONE_PULSE];
      end
      // new events win over a clear in the same cycle
      for (int i = 0; i < viu_pkg::N_STAT; i++) begin
         next_s.st[i] = (s.st[i] & ~clr[i]) | ev[i];
      end
      if (daisy) begin
         // never raise during acknowledge; chain input gates the line
         if ((s.ack != viu_pkg::DA_IDLE || link.irq_ack_in) && !s.irq) begin
            next_s.irq = 1'b0; // RULE8
         end else begin
            next_s.irq = pending & chain_in; // RULE14
         end
      end else begin
         next_s.irq = pending; // RULE2
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s <= '{st: '0, msk: '0, irq_port_config: viu_pkg::IPC_RESET, ack: viu_pkg::DA_IDLE,
                acc: 1'b0, grp: viu_pkg::GRP_NONE, vec: 8'h00, dout: 16'h0000,
                dout_oe: 1'b0, irq: 1'b0};
      end else begin
         s <= next_s;
      end
   end

   assign link.dev_data = s.dout;
   assign link.dev_data_oe = s.dout_oe;
   // open drain only pulls low; push-pull drives both levels
   assign link.irq_n_o = s.irq_port_config[viu_pkg::IPC_PUSH_PULL] ? ~s.irq : 1'b0; // RULE21
   assign link.irq_n_oe = s.irq_port_config[viu_pkg::IPC_PUSH_PULL] | s.irq;
   assign link.lo_dev_o = chain_in & ~s.irq; // RULE7
   assign link.lo_dev_oe = daisy;
   assign irq_active_o = s.irq;
   assign last_vector_o = s.vec;
endmodule // viu_device

//--- logic/viu_host.sv
// viu_host: APB-programmed controller that reads, writes and acknowledges the unit.
// assumes: one outstanding command at a time; software polls the busy bit.
`timescale 1ns/1ps
module viu_host (
   input  wire logic        clock_i,
   input  wire logic        arst_n_i,
   viu_link_if.host         link,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr
);
   typedef struct packed {
      viu_pkg::viu_hst_t st;
      logic [2:0]        cnt;
      logic [1:0]        op;
      logic [3:0]        addr;
      logic [7:0]        wdata;
      logic [7:0]        rdata;
      logic [4:0]        cfg;
      logic [31:0]       prd;
   } viu_hs_t;

   viu_hs_t s;
   viu_hs_t next_s;
   logic    acc_w;
   logic    acc_r;

   assign acc_w = psel & penable & pwrite;
   assign acc_r = psel & ~penable & ~pwrite;

   always_comb begin
      next_s = s;
      if (acc_r) begin
         case (paddr)
            viu_pkg::CT_CFG:    next_s.prd = {27'h0, s.cfg};
            viu_pkg::CT_STATUS: next_s.prd = {30'h0, ~link.irq_n, s.st != viu_pkg::HS_IDLE};
            viu_pkg::CT_DATA:   next_s.prd = {24'h0, s.rdata};
            default:            next_s.prd = 32'h0000_0000;
         endcase
      end
      if (acc_w && paddr == viu_pkg::CT_CFG) begin
         next_s.cfg = pwdata[4:0];
      end
      case (s.st)
         viu_pkg::HS_IDLE: begin
            if (acc_w && paddr == viu_pkg::CT_CMD) begin
               next_s.op = pwdata[viu_pkg::CMD_OP_LSB +: 2];
               next_s.addr = pwdata[viu_pkg::CMD_ADDR_LSB +: 4];
               next_s.wdata = pwdata[7:0];
               next_s.cnt = viu_pkg::ACK_PULSE_CYC;
               if (pwdata[viu_pkg::CMD_OP_LSB +: 2] == viu_pkg::OP_ACK) begin
                  next_s.st = s.cfg[viu_pkg::CFG_ONE_PULSE] ? viu_pkg::HS_P2
                                                            : viu_pkg::HS_P1; // RULE3
               end else if (pwdata[viu_pkg::CMD_OP_LSB +: 2] != 2'h0) begin
                  next_s.st = viu_pkg::HS_STB;
               end
            end
         end
         viu_pkg::HS_STB: next_s.st = viu_pkg::HS_CAP;
         viu_pkg::HS_CAP: begin
            if (s.op == viu_pkg::OP_READ) begin
               next_s.rdata = link.data[7:0];
            end
            next_s.st = viu_pkg::HS_IDLE;
         end
         viu_pkg::HS_P1, viu_pkg::HS_GAP, viu_pkg::HS_P2: begin
            next_s.cnt = s.cnt - 3'h1;
            if (s.cnt == 3'h1) begin
               next_s.cnt = viu_pkg::ACK_PULSE_CYC;
               if (s.st == viu_pkg::HS_P1) begin
                  next_s.st = viu_pkg::HS_GAP;
               end else if (s.st == viu_pkg::HS_GAP) begin
                  next_s.st = viu_pkg::HS_P2;
               end else begin
                  next_s.rdata = link.data[7:0]; // RULE9
                  next_s.st = viu_pkg::HS_IDLE;
               end
            end
         end
         default: next_s.st = viu_pkg::HS_IDLE;
      endcase
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s <= '{st: viu_pkg::HS_IDLE, cnt: 3'h0, op: 2'h0, addr: 4'h0, wdata: 8'h00,
                rdata: 8'h00, cfg: viu_pkg::CFG_RESET, prd: 32'h0000_0000};
      end else begin
         s <= next_s;
      end
   end

   assign prdata = s.prd;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign link.addr = s.addr;
   assign link.wdata = s.wdata;
   assign link.rd = (s.st == viu_pkg::HS_STB) && (s.op == viu_pkg::OP_READ);
   assign link.wr = (s.st == viu_pkg::HS_STB) && (s.op == viu_pkg::OP_WRITE);
   assign link.irq_ack_in = (s.st == viu_pkg::HS_P1) || (s.st == viu_pkg::HS_P2);
   // cascade address or chain enable as the system would strap them
   assign link.lo_host_o = s.cfg[viu_pkg::CFG_ADDR_LO]; // RULE5
   assign link.lo_host_oe = ~s.cfg[viu_pkg::CFG_DAISY];
   assign link.chain_en_in_or_addr_hi = s.cfg[viu_pkg::CFG_DAISY] ? s.cfg[viu_pkg::CFG_CHAIN_IN]
                                                                  : s.cfg[viu_pkg::CFG_ADDR_HI];
endmodule // viu_host

//--- logic/viu_link_if.sv
// viu_link_if: pins between the interrupt unit and its host-side controller.
// assumes: an undriven irq_n resolves high; other undriven shared pins resolve low.
`timescale 1ns/1ps
interface viu_link_if;
   logic [3:0]  addr;
   logic        rd;
   logic        wr;
   logic [7:0]  wdata;
   logic [15:0] dev_data;
   logic        dev_data_oe;
   logic        irq_ack_in;
   logic        irq_n_o;
   logic        irq_n_oe;
   logic        irq_n;
   logic        lo_dev_o;
   logic        lo_dev_oe;
   logic        lo_host_o;
   logic        lo_host_oe;
   logic        chain_en_out_or_addr_lo;
   logic        chain_en_in_or_addr_hi;
   logic [15:0] data;
   assign irq_n = irq_n_oe ? irq_n_o : 1'b1;
   assign chain_en_out_or_addr_lo = lo_dev_oe ? lo_dev_o : (lo_host_oe & lo_host_o);
   assign data = dev_data_oe ? dev_data : 16'h0000;
   modport dev (input addr, rd, wr, wdata, irq_ack_in, chain_en_out_or_addr_lo,
                chain_en_in_or_addr_hi,
                output dev_data, dev_data_oe, irq_n_o, irq_n_oe, lo_dev_o, lo_dev_oe);
   modport host (input data, irq_n, chain_en_out_or_addr_lo,
                 output addr, rd, wr, wdata, irq_ack_in, lo_host_o, lo_host_oe,
                 chain_en_in_or_addr_hi);
endinterface

//--- logic/viu_pkg.sv
// viu_pkg: constants shared by the vectored interrupt unit and its controller.
// assumes: both ends are compiled after this package.
package viu_pkg;
   localparam int unsigned N_STAT = 5;
   localparam int unsigned ST_W   = 8;
   localparam int unsigned D_W    = 16;
   localparam int unsigned A_W    = 4;
   // device register indices on the link bus
   localparam logic [3:0] IX_CH_STATUS_FIRST_A  = 4'h0;
   localparam logic [3:0] IX_CH_STATUS_SECOND_A = 4'h1;
   localparam logic [3:0] IX_CH_STATUS_FIRST_B  = 4'h2;
   localparam logic [3:0] IX_CH_STATUS_SECOND_B = 4'h3;
   localparam logic [3:0] IX_PORT_EVENT_STATUS  = 4'h4;
   localparam logic [3:0] IX_MASK_BASE          = 4'h5;
   localparam logic [3:0] IX_MASK_LAST          = 4'h9;
   localparam logic [3:0] IX_GLOBAL_POINTER     = 4'hA;
   localparam logic [3:0] IX_IRQ_PORT_CONFIG    = 4'hB;
   // irq_port_config fields
   localparam int unsigned IPC_PUSH_PULL = 0;
   localparam int unsigned IPC_DAISY     = 1;
   localparam int unsigned IPC_ADDR_LO   = 2;
   localparam int unsigned IPC_ADDR_HI   = 3;
   localparam int unsigned IPC_VISIBLE   = 4;
   localparam int unsigned IPC_ONE_PULSE = 5;
   localparam logic [7:0]  IPC_RESET     = 8'h00;
   localparam logic [7:0]  IPC_WMASK     = 8'h3F;
   // urgent status bit positions
   localparam int unsigned URG_RX0 = 0;
   localparam int unsigned URG_RX1 = 1;
   localparam int unsigned URG_TX0 = 0;
   localparam logic [7:0]  ST_OTHER_FIRST  = 8'hFC;
   localparam logic [7:0]  ST_OTHER_SECOND = 8'hFE;
   // vector layout: group number in [7:4], channel in [3]
   localparam int unsigned VEC_GRP_LSB = 4;
   localparam int unsigned VEC_CH_BIT  = 3;
   localparam logic [3:0]  GRP_NONE    = 4'h0;
   localparam logic [3:0]  GRP_LAST_URGENT = 4'h6;
   localparam logic [3:0]  GRP_7       = 4'h7;
   localparam logic [3:0]  GRP_8       = 4'h8;
   // controller APB map
   localparam logic [11:0] CT_CMD    = 12'h000;
   localparam logic [11:0] CT_CFG    = 12'h004;
   localparam logic [11:0] CT_STATUS = 12'h008;
   localparam logic [11:0] CT_DATA   = 12'h00C;
   localparam logic [1:0]  OP_READ   = 2'h1;
   localparam logic [1:0]  OP_WRITE  = 2'h2;
   localparam logic [1:0]  OP_ACK    = 2'h3;
   localparam int unsigned CMD_ADDR_LSB = 8;
   localparam int unsigned CMD_OP_LSB   = 12;
   localparam int unsigned CFG_ONE_PULSE = 0;
   localparam int unsigned CFG_ADDR_LO   = 1;
   localparam int unsigned CFG_ADDR_HI   = 2;
   localparam int unsigned CFG_CHAIN_IN  = 3;
   localparam int unsigned CFG_DAISY     = 4;
   localparam logic [4:0]  CFG_RESET     = 5'h08;
   // acknowledge pulse timing
   localparam int unsigned CLK_MHZ      = 100;
   localparam int unsigned ACK_PULSE_NS = 20;
   localparam logic [2:0]  ACK_PULSE_CYC = 3'((ACK_PULSE_NS * CLK_MHZ + 999) / 1000);
   typedef enum logic [2:0] {
      DA_IDLE = 3'h0, DA_P1 = 3'h1, DA_GAP = 3'h3, DA_P2 = 3'h2
   } viu_dack_t;
   typedef enum logic [2:0] {
      HS_IDLE = 3'h0, HS_STB = 3'h1, HS_CAP = 3'h3, HS_P1 = 3'h2,
      HS_GAP = 3'h6, HS_P2 = 3'h7
   } viu_hst_t;
endpackage

//--- sim/viu_props.sv
// viu_props: link-level checks between the interrupt unit and its controller.
// assumes: instantiated beside the link interface; one clock domain.
`timescale 1ns/1ps
module viu_props (
   input wire logic        clock_i,
   input wire logic        arst_n_i,
   input wire logic [3:0]  addr,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [7:0]  wdata,
   input wire logic        dev_data_oe,
   input wire logic        irq_ack_in,
   input wire logic        irq_n_o,
   input wire logic        irq_n_oe,
   input wire logic        irq_n,
   input wire logic        chain_en_out_or_addr_lo,
   input wire logic        chain_en_in_or_addr_hi,
   input wire logic [15:0] data
);
   logic [7:0] irq_port_config;
   logic       dsy;
   logic       pp;
   // shadow of the config register, so the checks know the mode
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         irq_port_config <= viu_pkg::IPC_RESET;
      end else if (wr && addr == viu_pkg::IX_IRQ_PORT_CONFIG) begin
         irq_port_config <= wdata & viu_pkg::IPC_WMASK;
      end
   end
   assign dsy = irq_port_config[viu_pkg::IPC_DAISY];
   assign pp  = irq_port_config[viu_pkg::IPC_PUSH_PULL];
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!arst_n_i);
   sequence s_quiet;
      !dev_data_oe [*3];
   endsequence
   sequence s_chain_off;
      (dsy && !chain_en_in_or_addr_hi) [*2];
   endsequence
   a_read_answer: assert property (rd |=> dev_data_oe)
      else $error("read not answered next cycle");
   a_upper_zero: assert property (dev_data_oe |-> data[15:8] == 8'h00)
      else $error("upper data byte driven");
   a_vec_shape: assert property (dev_data_oe && irq_ack_in |->
      data[2:0] == 3'h0 && data[7:4] <= viu_pkg::GRP_8)
      else $error("vector layout wrong");
   a_vec_stable: assert property (dev_data_oe && $past(dev_data_oe)
      && $past(irq_ack_in) |-> $stable(data[7:0]))
      else $error("vector changed during acknowledge");
   a_slave_refuse: assert property (!dsy && $rose(irq_ack_in) &&
      {chain_en_in_or_addr_hi, chain_en_out_or_addr_lo} !=
      irq_port_config[viu_pkg::IPC_ADDR_HI:viu_pkg::IPC_ADDR_LO] |=> s_quiet)
      else $error("acknowledge taken with wrong address");
   a_chain_refuse: assert property (dsy && $rose(irq_ack_in) &&
      !chain_en_in_or_addr_hi |=> s_quiet)
      else $error("acknowledge taken without chain enable");
   a_chain_block: assert property (dsy && $past(dsy) && !irq_n &&
      $past(irq_n) == 1'b0 |-> !chain_en_out_or_addr_lo)
      else $error("chain out active while requesting");
   a_chain_gate: assert property (s_chain_off |=> irq_n)
      else $error("request active without chain enable");
   a_no_new_irq: assert property (dsy && irq_ack_in &&
      $past(irq_ack_in) |-> !$fell(irq_n))
      else $error("request raised during acknowledge");
   a_open_drain: assert property (!pp && irq_n_oe |-> !irq_n_o)
      else $error("open drain pin driven high");
   a_push_pull: assert property (pp && $past(pp) |-> irq_n_oe)
      else $error("push-pull pin not driven");
endmodule // viu_props

//--- sim/viu_tb_top.sv
// viu_tb_top: drives the controller over APB and events into the unit.
// assumes: both ends joined by one link interface; checker sits beside it.
`timescale 1ns/1ps
module viu_tb_top;
   logic        clk;
   logic        arst_n;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        irq_act;
   logic [7:0]  last_vec;
   logic [7:0]  ev [5];
   int          err_count;
   int          check_count;
   viu_link_if lnk ();
   viu_device u_viu_device (.clock_i(clk), .arst_n_i(arst_n), .link(lnk),
      .ev_first_a_i(ev[0]), .ev_second_a_i(ev[1]), .ev_first_b_i(ev[2]),
      .ev_second_b_i(ev[3]), .ev_port_i(ev[4]), .irq_active_o(irq_act),
      .last_vector_o(last_vec));
   viu_host u_viu_host (.clock_i(clk), .arst_n_i(arst_n), .link(lnk), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr());
   viu_props u_viu_props (.clock_i(clk), .arst_n_i(arst_n), .addr(lnk.addr),
      .wr(lnk.wr), .rd(lnk.rd), .wdata(lnk.wdata), .dev_data_oe(lnk.dev_data_oe),
      .irq_ack_in(lnk.irq_ack_in), .irq_n_o(lnk.irq_n_o), .irq_n_oe(lnk.irq_n_oe),
      .irq_n(lnk.irq_n), .chain_en_out_or_addr_lo(lnk.chain_en_out_or_addr_lo),
      .chain_en_in_or_addr_hi(lnk.chain_en_in_or_addr_hi), .data(lnk.data));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk8({7'h00, got}, {7'h00, exp});
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   // software polls busy; a stuck controller is caught by the watchdog
   task automatic cmd(input logic [1:0] op, input logic [3:0] ix, input logic [7:0] v,
                      output logic [7:0] r);
      logic [31:0] s;
      apb(1'b1, viu_pkg::CT_CMD, {18'h0, op, ix, v}, s);
      s = 32'h0000_0001;
      while (s[0] === 1'b1) apb(1'b0, viu_pkg::CT_STATUS, 32'h0000_0000, s);
      apb(1'b0, viu_pkg::CT_DATA, 32'h0000_0000, s);
      r = s[7:0];
   endtask
   task automatic rdc(input logic [3:0] ix, input logic [7:0] exp);
      logic [7:0] r;
      cmd(viu_pkg::OP_READ, ix, 8'h00, r);
      chk8(r, exp);
   endtask
   task automatic wrd(input logic [3:0] ix, input logic [7:0] v);
      logic [7:0] r;
      cmd(viu_pkg::OP_WRITE, ix, v, r);
   endtask
   task automatic ackc(input logic [7:0] exp);
      logic [7:0] r;
      cmd(viu_pkg::OP_ACK, 4'h0, 8'h00, r);
      chk8(r, exp);
   endtask
   task automatic cfg(input logic [31:0] v);
      logic [31:0] r;
      apb(1'b1, viu_pkg::CT_CFG, v, r);
   endtask
   task automatic irqc(input logic exp);
      logic [31:0] r;
      repeat (3) @(posedge clk);
      apb(1'b0, viu_pkg::CT_STATUS, 32'h0000_0000, r);
      chk1(r[1], exp);
      chk1(irq_act, exp);
   endtask
   task automatic fire(input int k, input logic [7:0] b);
      @(posedge clk);
      ev[k] <= b;
      @(posedge clk);
      ev[k] <= 8'h00;
   endtask
   task automatic t_reset();
      logic [31:0] r;
      apb(1'b0, viu_pkg::CT_CFG, 32'h0000_0000, r);
      chk8(r[7:0], {3'h0, viu_pkg::CFG_RESET});
      rdc(viu_pkg::IX_IRQ_PORT_CONFIG, viu_pkg::IPC_RESET);
      rdc(viu_pkg::IX_GLOBAL_POINTER, 8'h00);
      rdc(4'hF, 8'h00);
      chk1(lnk.irq_n_oe, 1'b0);
      $display("t_reset done");
   endtask
   task automatic t_poll();
      fire(1, 8'h04);
      fire(4, 8'h01);
      irqc(1'b1);
      rdc(viu_pkg::IX_GLOBAL_POINTER, 8'h12);
      rdc(viu_pkg::IX_CH_STATUS_SECOND_A, 8'h04);
      rdc(viu_pkg::IX_GLOBAL_POINTER, 8'h10);
      irqc(1'b1);
      rdc(viu_pkg::IX_PORT_EVENT_STATUS, 8'h01);
      rdc(viu_pkg::IX_PORT_EVENT_STATUS, 8'h00);
      irqc(1'b0);
      $display("t_poll done");
   endtask
   task automatic t_vector();
      logic [7:0] vec [3] = '{8'h10, 8'h48, 8'h68};
      fire(3, 8'h01);
      fire(2, 8'h02);
      fire(0, 8'h01);
      for (int i = 0; i < 3; i++) begin
         ackc(vec[i]);
      end
      chk8(last_vec, 8'h68);
      rdc(viu_pkg::IX_GLOBAL_POINTER, 8'h00);
      irqc(1'b0);
      wrd(viu_pkg::IX_IRQ_PORT_CONFIG, 8'h20);
      cfg(32'h0000_0009);
      fire(0, 8'h01);
      ackc(8'h10);
      rdc(viu_pkg::IX_CH_STATUS_FIRST_A, 8'h00);
      wrd(viu_pkg::IX_IRQ_PORT_CONFIG, 8'h00);
      cfg(32'h0000_0008);
      $display("t_vector done");
   endtask
   task automatic t_group();
      fire(4, 8'h08);
      ackc(8'h70);
      rdc(viu_pkg::IX_GLOBAL_POINTER, 8'h10);
      rdc(viu_pkg::IX_PORT_EVENT_STATUS, 8'h08);
      fire(3, 8'h10);
      fire(4, 8'h01);
      ackc(8'h70);
      rdc(viu_pkg::IX_PORT_EVENT_STATUS, 8'h01);
      ackc(8'h88);
      rdc(viu_pkg::IX_GLOBAL_POINTER, 8'h08);
      rdc(viu_pkg::IX_CH_STATUS_SECOND_B, 8'h10);
      irqc(1'b0);
      $display("t_group done");
   endtask
   task automatic t_mask();
      wrd(viu_pkg::IX_MASK_BASE, 8'h01);
      fire(0, 8'h03);
      rdc(viu_pkg::IX_GLOBAL_POINTER, 8'h01);
      ackc(8'h30);
      irqc(1'b0);
      rdc(viu_pkg::IX_CH_STATUS_FIRST_A, 8'h00);
      wrd(viu_pkg::IX_MASK_BASE, 8'h00);
      irqc(1'b1);
      rdc(viu_pkg::IX_CH_STATUS_FIRST_A, 8'h01);
      wrd(viu_pkg::IX_IRQ_PORT_CONFIG, 8'h10);
      wrd(viu_pkg::IX_MASK_LAST, 8'hFF);
      fire(4, 8'h05);
      irqc(1'b0);
      rdc(viu_pkg::IX_GLOBAL_POINTER, 8'h00);
      rdc(viu_pkg::IX_PORT_EVENT_STATUS, 8'h05);
      rdc(viu_pkg::IX_PORT_EVENT_STATUS, 8'h00);
      wrd(viu_pkg::IX_MASK_LAST, 8'h00);
      irqc(1'b0);
      wrd(viu_pkg::IX_IRQ_PORT_CONFIG, 8'h00);
      $display("t_mask done");
   endtask
   task automatic t_cascade();
      wrd(viu_pkg::IX_IRQ_PORT_CONFIG, 8'h08);
      cfg(32'h0000_0002);
      fire(0, 8'h01);
      ackc(8'h00);
      irqc(1'b1);
      cfg(32'h0000_000C);
      ackc(8'h10);
      wrd(viu_pkg::IX_IRQ_PORT_CONFIG, 8'h02);
      cfg(32'h0000_0018);
      fire(0, 8'h01);
      irqc(1'b1);
      chk1(lnk.chain_en_out_or_addr_lo, 1'b0);
      cfg(32'h0000_0010);
      irqc(1'b0);
      ackc(8'h00);
      cfg(32'h0000_0018);
      ackc(8'h10);
      irqc(1'b0);
      chk1(lnk.chain_en_out_or_addr_lo, 1'b1);
      wrd(viu_pkg::IX_IRQ_PORT_CONFIG, 8'h01);
      cfg(32'h0000_0008);
      chk1(lnk.irq_n_oe, 1'b1);
      fire(0, 8'h01);
      irqc(1'b1);
      chk1(lnk.irq_n, 1'b0);
      ackc(8'h10);
      $display("t_cascade done");
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      arst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      foreach (ev[i]) ev[i] = 8'h00;
      err_count = 0;
      check_count = 0;
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      t_reset();
      t_poll();
      t_vector();
      t_group();
      t_mask();
      t_cascade();
      stop_test();
   end
   // full run needs well under a thousand cycles; allow ample margin
   initial begin
      #400_000;
      err_count++;
      $display("mismatch t=%0t watchdog expired", $time);
      stop_test();
   end
endmodule // viu_tb_top
